// *** design/pmc_power_mode_controller.sv ***
// Power mode controller: run, idle and sleep sequencing with clock source control.
// Functional notes
// - Select 00 primary, 01 secondary, 1x internal.
// - Sleep with idle clear stops all clocks.
// - Sleep with idle set gates CPU only.
// - Reset always enters primary run; two-speed is cleared and acts on sleep wake only.
// - Select 01 switches to secondary, updates flags.
// - Secondary switch waits for enable and ready.
// - Internal select shuts primary, clears ready flag.
// - Frequency select changes apply immediately.
// - Sleep entry stops oscillator, clears status flags.
// - Timer1 and, with watchdog select or fail-safe set, slow internal keep running.
// - Sleep wake waits source ready or internal.
// - Wake leaves idle and select bits unchanged.
// - Idle keeps peripherals clocked, flags unchanged.
// - Wake holds CPU for ready delay.
// - Watchdog wakes in low power, resets in run.
// - Primary idle keeps primary and ready flag.
// - Secondary idle without enable keeps previous clock.
// - Upper select bit overrides lower bit.
// - Fast internal enabled, stable after interval.
// - All-zero frequency select with source bit clear keeps stable clear.
// - Interrupt wake resumes after sleep instruction.
// - Watchdog counter cleared on listed events.
// - Reset exit restarts at address zero.
`timescale 1ns/1ps
module pmc_power_mode_controller #(
    parameter int CSD_COUNT = pmc_pkg::CSD_CYCLES
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_wake,
    input wire logic global_irq_enable,
    input wire logic watchdog_timeout,
    input wire logic clock_fail,
    input wire logic primary_osc_ready,
    input wire logic secondary_osc_ready,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic [1:0] sys_clk_src,
    output logic [2:0] internal_freq_out,
    output logic primary_osc_en,
    output logic secondary_osc_en,
    output logic fast_internal_osc_en,
    output logic slow_internal_osc_en,
    output logic watchdog_clear,
    output logic watchdog_reset,
    output logic irq_vector_take,
    output logic restart_zero
);
    typedef struct packed {
        pmc_pkg::pmc_state_t st;
        logic idle_select;
        logic [1:0] clock_source_select;
        logic [2:0] internal_freq_select;
        logic internal_source_bit;
        logic two_speed;
        logic fail_safe;
        logic wdt_sel;
        logic secondary_osc_enable;
        pmc_pkg::pmc_src_t src;
        logic primary_ready_flag;
        logic timer_one_running_flag;
        logic internal_stable_flag;
        logic [7:0] iob_cnt;
        logic [7:0] csd_cnt;
        logic wake_irq;
        logic wdt_clr;
        logic wdt_rst;
        logic vec_take;
        logic rst_zero;
        logic [31:0] rdata;
    } pmc_regs_t;

    pmc_regs_t s_reg;
    pmc_regs_t s_next;
    logic rd_en;
    logic wr_en;
    logic [1:0] want_src_reg_sel;
    logic pri_rdy_sync1_reg;
    logic pri_rdy_sync2_reg;
    logic sec_rdy_sync1_reg;
    logic sec_rdy_sync2_reg;

    // Read data is loaded in the setup phase, so it stands when the access edge takes it.
    assign rd_en = psel && !penable && !pwrite;
    assign wr_en = psel && penable && pwrite;
    assign want_src_reg_sel = s_reg.clock_source_select;

    // Oscillator ready levels come from analog cells, so they are synchronised.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pri_rdy_sync1_reg <= 1'b0;
            pri_rdy_sync2_reg <= 1'b0;
            sec_rdy_sync1_reg <= 1'b0;
            sec_rdy_sync2_reg <= 1'b0;
        end else begin
            pri_rdy_sync1_reg <= primary_osc_ready;
            pri_rdy_sync2_reg <= pri_rdy_sync1_reg;
            sec_rdy_sync1_reg <= secondary_osc_ready;
            sec_rdy_sync2_reg <= sec_rdy_sync1_reg;
        end
    end

    function automatic pmc_pkg::pmc_src_t decode_src(input logic [1:0] sel);
        pmc_pkg::pmc_src_t r;
        r = pmc_pkg::SRC_PRI;
        if (sel[1]) begin
            r = pmc_pkg::SRC_INT;
        end else if (sel == pmc_pkg::SCS_SECONDARY) begin
            r = pmc_pkg::SRC_SEC;
        end
        return r;
    endfunction

    always_comb begin
        pmc_pkg::pmc_src_t want;
        logic sec_ok;
        logic fast_on;
        logic sleep_cmd;
        logic [2:0] new_internal_freq_select;
        want = decode_src(s_reg.clock_source_select);
        sec_ok = s_reg.secondary_osc_enable && sec_rdy_sync2_reg;
        fast_on = (s_reg.internal_freq_select != 3'h0) || s_reg.internal_source_bit;
        sleep_cmd = wr_en && (paddr == pmc_pkg::OFF_CMD) && pwdata[pmc_pkg::CMD_SLEEP_BIT];
        new_internal_freq_select = pwdata[pmc_pkg::INTERNAL_FREQ_SELECT_LSB +: 3];
        s_next = s_reg;
        s_next.wdt_clr = 1'b0;
        s_next.wdt_rst = 1'b0;
        s_next.vec_take = 1'b0;
        s_next.rst_zero = 1'b0;
        s_next.rdata = 32'h0;
        // Register writes; the state machine never alters idle or select bits.
        if (wr_en) begin
            case (paddr)
                pmc_pkg::OFF_OSC_CTRL: begin
                    s_next.clock_source_select = pwdata[pmc_pkg::SCS_LSB +: 2];
                    s_next.internal_freq_select = new_internal_freq_select;
                    s_next.idle_select = pwdata[pmc_pkg::IDLE_BIT];
                    s_next.internal_source_bit = pwdata[pmc_pkg::INTERNAL_SOURCE_BIT_BIT];
                    s_next.two_speed = pwdata[pmc_pkg::TWO_SPEED_BIT];
                    s_next.fail_safe = pwdata[pmc_pkg::FAILSAFE_BIT];
                    s_next.wdt_sel = pwdata[pmc_pkg::WDT_SEL_BIT];
                    if (s_reg.src == pmc_pkg::SRC_INT && new_internal_freq_select != s_reg.internal_freq_select) begin
                        s_next.wdt_clr = 1'b1;
                    end
                end
                pmc_pkg::OFF_TMR1_CTRL: begin
                    s_next.secondary_osc_enable = pwdata[0];
                end
                pmc_pkg::OFF_CMD: begin
                    if (pwdata[pmc_pkg::CMD_WATCHDOG_CLEAR_INSTR_BIT]) begin
                        s_next.wdt_clr = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd_en) begin
            case (paddr)
                pmc_pkg::OFF_OSC_CTRL: begin
                    s_next.rdata = {20'h0, s_reg.wdt_sel, s_reg.fail_safe, s_reg.two_speed,
                        s_reg.internal_source_bit, s_reg.idle_select,
                        s_reg.internal_freq_select, 2'h0, s_reg.clock_source_select};
                end
                pmc_pkg::OFF_TMR1_CTRL: begin
                    s_next.rdata = {31'h0, s_reg.secondary_osc_enable};
                end
                pmc_pkg::OFF_STATUS: begin
                    s_next.rdata = {24'h0, 1'b0, s_reg.st, s_reg.timer_one_running_flag,
                        s_reg.internal_stable_flag, s_reg.primary_ready_flag, 1'b0};
                end
                default: begin
                end
            endcase
        end
        if (s_reg.fail_safe && clock_fail) begin
            s_next.wdt_clr = 1'b1;
        end
        if (fast_on && s_reg.st != pmc_pkg::PMC_SLEEP) begin
            if (s_reg.iob_cnt < 8'(pmc_pkg::IOBST_CYCLES)) begin
                s_next.iob_cnt = s_reg.iob_cnt + 8'h1;
            end else begin
                s_next.internal_stable_flag = 1'b1;
            end
        end else begin
            // No fast output, flag stays clear.
            s_next.iob_cnt = 8'h0;
            s_next.internal_stable_flag = 1'b0;
        end
        case (s_reg.st)
            pmc_pkg::PMC_RUN: begin
                if (want == pmc_pkg::SRC_SEC) begin
                    if (sec_ok) begin
                        s_next.src = pmc_pkg::SRC_SEC;
                        s_next.timer_one_running_flag = 1'b1;
                        s_next.primary_ready_flag = 1'b0;
                    end
                end else if (want == pmc_pkg::SRC_INT) begin
                    s_next.src = pmc_pkg::SRC_INT;
                    s_next.primary_ready_flag = 1'b0;
                    s_next.timer_one_running_flag = 1'b0;
                end else if (pri_rdy_sync2_reg) begin
                    s_next.src = pmc_pkg::SRC_PRI;
                    s_next.primary_ready_flag = 1'b1;
                    s_next.timer_one_running_flag = 1'b0;
                end
                if (watchdog_timeout) begin
                    s_next.wdt_rst = 1'b1;
                end else if (sleep_cmd) begin
                    s_next.wdt_clr = 1'b1;
                    if (s_reg.idle_select) begin
                        // Idle keeps current source and flags.
                        s_next.st = pmc_pkg::PMC_IDLE;
                    end else begin
                        // Sleep stops clocks and clears flags.
                        s_next.st = pmc_pkg::PMC_SLEEP;
                        s_next.src = pmc_pkg::SRC_NONE;
                        s_next.primary_ready_flag = 1'b0;
                        s_next.timer_one_running_flag = 1'b0;
                        s_next.internal_stable_flag = 1'b0;
                        s_next.iob_cnt = 8'h0;
                    end
                end
            end
            pmc_pkg::PMC_IDLE, pmc_pkg::PMC_SLEEP: begin
                // Wake on interrupt or watchdog; bits untouched.
                if (irq_wake || watchdog_timeout) begin
                    s_next.wake_irq = irq_wake;
                    // Ready delay starts at the wake event.
                    s_next.csd_cnt = 8'h0;
                    s_next.st = (s_reg.st == pmc_pkg::PMC_SLEEP) ?
                        pmc_pkg::PMC_WAKE_WAIT : pmc_pkg::PMC_CSD;
                end
            end
            pmc_pkg::PMC_WAKE_WAIT: begin
                if (s_reg.csd_cnt < 8'(CSD_COUNT)) begin
                    s_next.csd_cnt = s_reg.csd_cnt + 8'h1;
                end
                // Clock once source ready, or internal when allowed.
                if ((want == pmc_pkg::SRC_PRI && pri_rdy_sync2_reg) ||
                    (want == pmc_pkg::SRC_SEC && sec_ok) || want == pmc_pkg::SRC_INT) begin
                    s_next.src = want;
                    s_next.primary_ready_flag = (want == pmc_pkg::SRC_PRI);
                    s_next.timer_one_running_flag = (want == pmc_pkg::SRC_SEC);
                    s_next.st = pmc_pkg::PMC_CSD;
                end else if (s_reg.two_speed || s_reg.fail_safe) begin
                    s_next.src = pmc_pkg::SRC_INT;
                end
            end
            pmc_pkg::PMC_CSD: begin
                // CPU held at least CSD_COUNT cycles from the wake; longer if the sleep wait outlasts it.
                if (s_reg.csd_cnt < 8'(CSD_COUNT - 1)) begin
                    s_next.csd_cnt = s_reg.csd_cnt + 8'h1;
                end else begin
                    s_next.st = pmc_pkg::PMC_RUN;
                    // Vector only when global enable is set.
                    s_next.vec_take = s_reg.wake_irq && global_irq_enable;
                end
            end
            default: begin
                s_next.st = pmc_pkg::PMC_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            // Primary run after reset; restart at address zero.
            s_reg <= '0;
            s_reg.st <= pmc_pkg::PMC_RUN;
            s_reg.src <= pmc_pkg::SRC_PRI;
            s_reg.clock_source_select <= pmc_pkg::SCS_RESET;
            s_reg.internal_freq_select <= pmc_pkg::INTERNAL_FREQ_SELECT_RESET;
            s_reg.rst_zero <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign cpu_clk_en = (s_reg.st == pmc_pkg::PMC_RUN) && (s_reg.src != pmc_pkg::SRC_NONE);
    assign periph_clk_en = (s_reg.st == pmc_pkg::PMC_RUN || s_reg.st == pmc_pkg::PMC_IDLE ||
        s_reg.st == pmc_pkg::PMC_CSD) && (s_reg.src != pmc_pkg::SRC_NONE);
    assign sys_clk_src = s_reg.src;
    assign internal_freq_out = s_reg.internal_freq_select;
    // Primary kept on only while it is the source or being waited for.
    assign primary_osc_en = (s_reg.src == pmc_pkg::SRC_PRI) ||
        (s_reg.st == pmc_pkg::PMC_WAKE_WAIT && want_src_reg_sel == pmc_pkg::SCS_PRIMARY) ||
        (s_reg.st == pmc_pkg::PMC_RUN && want_src_reg_sel == pmc_pkg::SCS_PRIMARY);
    // Timer1 survives low power; slow internal survives sleep only with watchdog select or fail-safe set.
    assign secondary_osc_en = s_reg.secondary_osc_enable;
    assign slow_internal_osc_en = s_reg.wdt_sel || s_reg.fail_safe ||
        s_reg.src == pmc_pkg::SRC_INT;
    assign fast_internal_osc_en = s_reg.st != pmc_pkg::PMC_SLEEP &&
        (s_reg.internal_freq_select != 3'h0 || s_reg.internal_source_bit);
    assign watchdog_clear = s_reg.wdt_clr;
    assign watchdog_reset = s_reg.wdt_rst;
    assign irq_vector_take = s_reg.vec_take;
    assign restart_zero = s_reg.rst_zero;

    sleep_clk_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_SLEEP |-> !cpu_clk_en && !periph_clk_en) else
        $error("clock running in sleep");
    idle_gate_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_IDLE |-> !cpu_clk_en && periph_clk_en) else
        $error("idle clock gating wrong");
    sleep_flags_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(s_reg.st == pmc_pkg::PMC_SLEEP) |-> !s_reg.primary_ready_flag &&
        !s_reg.timer_one_running_flag) else $error("flags set in sleep");
    sequence wake_seq;
        s_reg.st == pmc_pkg::PMC_CSD && s_reg.csd_cnt == 8'h0;
    endsequence
    csd_delay_a: assert property (@(posedge mclk) disable iff (srst)
        wake_seq |-> !cpu_clk_en [*8] ##1 s_reg.st == pmc_pkg::PMC_RUN) else
        $error("ready delay wrong");
    wdt_run_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_RUN && watchdog_timeout |=> watchdog_reset) else
        $error("no watchdog reset");
    sel_keep_a: assert property (@(posedge mclk) disable iff (srst)
        !srst && s_reg.st != pmc_pkg::PMC_RUN && !wr_en |=>
        $stable(s_reg.clock_source_select) &&
        $stable(s_reg.idle_select)) else $error("select bits changed");
    idle_flags_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_IDLE && $past(s_reg.st) == pmc_pkg::PMC_IDLE |->
        $stable(s_reg.primary_ready_flag)) else $error("idle flag changed");
    stable_clr_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.internal_freq_select == 3'h0 && !s_reg.internal_source_bit |=>
        !s_reg.internal_stable_flag) else $error("stable flag set");
    sequence sleep_req_seq;
        s_reg.st == pmc_pkg::PMC_RUN && wr_en && paddr == pmc_pkg::OFF_CMD &&
            pwdata[pmc_pkg::CMD_SLEEP_BIT] && !watchdog_timeout;
    endsequence
    sleep_entry_a: assert property (@(posedge mclk) disable iff (srst)
        sleep_req_seq |=> watchdog_clear && s_reg.st != pmc_pkg::PMC_RUN) else
        $error("sleep entry wrong");
    vector_gate_a: assert property (@(posedge mclk) disable iff (srst)
        irq_vector_take |-> $past(global_irq_enable)) else
        $error("vector without global enable");
    primary_idle_mode_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_IDLE && s_reg.src == pmc_pkg::SRC_PRI |->
        primary_osc_en) else $error("primary idle lost");
    keep_osc_a: assert property (@(posedge mclk) disable iff (srst)
        s_reg.st == pmc_pkg::PMC_SLEEP |-> secondary_osc_en == s_reg.secondary_osc_enable &&
        (slow_internal_osc_en || !s_reg.wdt_sel)) else $error("low power oscillator off");
endmodule // pmc_power_mode_controller

// *** design/pmc_pkg.sv ***
// Package with constants, register map and types of the power mode controller.
package pmc_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_TMR1_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    // Field positions in the oscillator control register.
    localparam int SCS_LSB = 0;
    localparam int INTERNAL_FREQ_SELECT_LSB = 4;
    localparam int IDLE_BIT = 7;
    localparam int INTERNAL_SOURCE_BIT_BIT = 8;
    localparam int TWO_SPEED_BIT = 9;
    localparam int FAILSAFE_BIT = 10;
    localparam int WDT_SEL_BIT = 11;
    // Command register bits; writing a one issues the instruction.
    localparam int CMD_SLEEP_BIT = 0;
    localparam int CMD_WATCHDOG_CLEAR_INSTR_BIT = 1;
    // Clock source select encodings.
    localparam logic [1:0] SCS_PRIMARY = 2'h0;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    // Reset values.
    localparam logic [1:0] SCS_RESET = 2'h0;
    localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h3;
    // Timing constants.
    localparam int CLK_MHZ = 25;
    localparam int IOBST_NS = 1000;
    localparam int IOBST_CYCLES = (IOBST_NS * CLK_MHZ + 999) / 1000;
    localparam int CSD_CYCLES = 8;
    localparam logic [31:0] RESET_VECTOR = 32'h0;
    typedef enum logic [2:0] {
        PMC_RUN = 3'b000,
        PMC_IDLE = 3'b001,
        PMC_SLEEP = 3'b010,
        PMC_WAKE_WAIT = 3'b011,
        PMC_CSD = 3'b100
    } pmc_state_t;
    typedef enum logic [1:0] {
        SRC_PRI = 2'b00,
        SRC_SEC = 2'b01,
        SRC_INT = 2'b10,
        SRC_NONE = 2'b11
    } pmc_src_t;
endpackage

// *** tb/pmc_far_model.sv ***
// Far side model: oscillators with a start-up time and one gated interrupt source.
`timescale 1ns/1ps
module pmc_far_model #(
    parameter int START_CYC = 12
) (
    input wire logic mclk,
    input wire logic primary_osc_en,
    input wire logic secondary_osc_en,
    input wire logic irq_flag,
    input wire logic irq_src_en,
    input wire logic irq_periph,
    input wire logic periph_irq_en,
    output logic primary_osc_ready,
    output logic secondary_osc_ready,
    output logic irq_wake
);
    int pri_cnt = 0;
    int sec_cnt = 0;
    // A stopped oscillator drops ready at once, so a controller that trusts a stale flag fails.
    always @(posedge mclk) begin
        // An enable that is not a clean one counts as off, so an unknown cannot stick.
        pri_cnt <= (primary_osc_en === 1'b1) ? pri_cnt + int'(pri_cnt < START_CYC) : 0;
        sec_cnt <= (secondary_osc_en === 1'b1) ? sec_cnt + int'(sec_cnt < START_CYC) : 0;
    end
    assign primary_osc_ready = (pri_cnt >= START_CYC);
    assign secondary_osc_ready = (sec_cnt >= START_CYC);
    assign irq_wake = irq_flag & irq_src_en & (~irq_periph | periph_irq_en);
endmodule // pmc_far_model

// *** tb/tb_power_mode_controller.sv ***
// Self-checking testbench of the power mode controller.
`timescale 1ns/1ps
module tb_power_mode_controller;
    localparam int CSD = 8;
    logic mclk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic irq_flag, irq_src_en, irq_periph, periph_irq_en, irq_wake, pri_rdy, sec_rdy;
    logic global_irq_enable, watchdog_timeout, clock_fail, cpu_clk_en, periph_clk_en;
    logic primary_osc_en, secondary_osc_en, fast_en, slow_en;
    logic watchdog_clear, watchdog_reset, irq_vector_take, restart_zero;
    logic [1:0] sys_clk_src;
    logic [2:0] freq_out;
    logic [31:0] rd_exp[$];
    logic [31:0] rd_mask[$];
    int error_cnt = 0;
    int checked = 0;
    int clr_cnt = 0;
    int rst_cnt = 0;
    int vec_cnt = 0;
    pmc_power_mode_controller #(.CSD_COUNT(CSD)) uut (.mclk(mclk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_wake(irq_wake),
        .global_irq_enable(global_irq_enable), .watchdog_timeout(watchdog_timeout),
        .clock_fail(clock_fail), .primary_osc_ready(pri_rdy), .secondary_osc_ready(sec_rdy),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .sys_clk_src(sys_clk_src),
        .internal_freq_out(freq_out), .primary_osc_en(primary_osc_en),
        .secondary_osc_en(secondary_osc_en), .fast_internal_osc_en(fast_en),
        .slow_internal_osc_en(slow_en), .watchdog_clear(watchdog_clear),
        .watchdog_reset(watchdog_reset), .irq_vector_take(irq_vector_take),
        .restart_zero(restart_zero));
    pmc_far_model far (.mclk(mclk), .primary_osc_en(primary_osc_en),
        .secondary_osc_en(secondary_osc_en), .irq_flag(irq_flag), .irq_src_en(irq_src_en),
        .irq_periph(irq_periph), .periph_irq_en(periph_irq_en), .primary_osc_ready(pri_rdy),
        .secondary_osc_ready(sec_rdy), .irq_wake(irq_wake));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // Read data stands through the access phase, so the monitor takes it at the access edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        if (!w) begin
            rd_exp.push_back(d & m);
            rd_mask.push_back(m);
        end
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_cpu(input int lim, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (cpu_clk_en !== 1'b1 && n < lim);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        clr_cnt <= clr_cnt + int'(watchdog_clear === 1'b1);
        rst_cnt <= rst_cnt + int'(watchdog_reset === 1'b1);
        vec_cnt <= vec_cnt + int'(irq_vector_take === 1'b1);
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            chk("slave error", 32'h0, pslverr);
            if (pwrite === 1'b0) begin
                chk("read data", rd_exp.pop_front(), prdata & rd_mask.pop_front());
            end
        end
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
    initial begin
        int c0, v0, n, r0, v;
        {psel, penable, pwrite, paddr, pwdata, irq_flag} = '0;
        {irq_src_en, irq_periph, periph_irq_en} = 3'h7;
        {global_irq_enable, watchdog_timeout, clock_fail} = 3'h0;
        srst = 1'b1;
        v = $urandom(32'h9AED1A7C);
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (40) @(posedge mclk);
        apb(1'b0, pmc_pkg::OFF_OSC_CTRL, 32'h30, 32'hFFF); // control defaults
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h2, 32'h72); // primary run
        apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
        for (int g = 1; g >= 0; g--) begin
            global_irq_enable <= g[0];
            c0 = clr_cnt;
            v0 = vec_cnt;
            apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'hB0, 32'h0);
            apb(1'b1, pmc_pkg::OFF_CMD, 32'h1, 32'h0);
            repeat (3) @(posedge mclk);
            chk("idle clocks", 32'h1, {cpu_clk_en, periph_clk_en});
            chk("primary osc", 32'h1, primary_osc_en); // primary kept
            apb(1'b0, pmc_pkg::OFF_STATUS, 32'h12, 32'h72); // flags kept
            @(posedge mclk);
            irq_flag <= 1'b1;
            wait_cpu(60, n);
            irq_flag <= 1'b0;
            chk("ready delay", CSD + 2, n);
            repeat (2) @(posedge mclk);
            chk("vector taken", g, vec_cnt - v0);
            chk("watchdog clears", 32'h1, clr_cnt - c0);
            apb(1'b0, pmc_pkg::OFF_OSC_CTRL, 32'hB0, 32'hFFF); // bits unchanged
        end
        apb(1'b1, pmc_pkg::OFF_TMR1_CTRL, 32'h1, 32'h0);
        apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h830, 32'h0);
        apb(1'b1, pmc_pkg::OFF_CMD, 32'h1, 32'h0);
        repeat (3) @(posedge mclk);
        chk("sleep clocks", 32'h0, {cpu_clk_en, periph_clk_en});
        chk("primary osc", 32'h0, primary_osc_en);
        chk("kept oscillators", 32'h3, {slow_en, secondary_osc_en});
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h20, 32'h7E); // flags cleared
        r0 = rst_cnt;
        @(posedge mclk);
        watchdog_timeout <= 1'b1;
        @(posedge mclk);
        watchdog_timeout <= 1'b0;
        wait_cpu(200, n);
        chk("sleep wake done", 32'h1, n < 200);
        chk("watchdog resets", 32'h0, rst_cnt - r0); // wake only
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h2, 32'h72); // primary ready
        @(posedge mclk);
        watchdog_timeout <= 1'b1;
        @(posedge mclk);
        watchdog_timeout <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("watchdog resets", 32'h1, rst_cnt - r0); // reset in run
        apb(1'b1, pmc_pkg::OFF_TMR1_CTRL, 32'h0, 32'h0);
        apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h31, 32'h0);
        repeat (10) @(posedge mclk);
        chk("deferred source", pmc_pkg::SRC_PRI, sys_clk_src);
        apb(1'b1, pmc_pkg::OFF_TMR1_CTRL, 32'h1, 32'h0);
        for (int s = 1; s <= 4; s++) begin
            apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h30 | 32'(s % 4), 32'h0);
            repeat (40) @(posedge mclk);
            chk("clock source", s == 1 ? pmc_pkg::SRC_SEC : s == 4 ? pmc_pkg::SRC_PRI :
                pmc_pkg::SRC_INT, sys_clk_src);
            chk("primary osc", 32'(s == 4), primary_osc_en);
            apb(1'b0, pmc_pkg::OFF_STATUS, s == 1 ? 32'h8 : s == 4 ? 32'h2 : 32'h0,
                s == 1 ? 32'hA : 32'h2); // flags
        end
        apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h32, 32'h0);
        repeat (30) @(posedge mclk);
        v = 3;
        for (int k = 0; k < 4; k++) begin
            v = ((v + $urandom % 6) % 7) + 1;
            c0 = clr_cnt;
            apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h2 | 32'(v << 4), 32'h0);
            repeat (2) @(posedge mclk);
            chk("frequency", v, freq_out);
            chk("fast osc enable", 32'h1, fast_en);
            chk("watchdog clears", 32'h1, clr_cnt - c0);
        end
        repeat (30) @(posedge mclk);
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h4, 32'h4); // stable flag
        apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'h0, 32'h0);
        repeat (40) @(posedge mclk);
        chk("fast osc enable", 32'h0, fast_en);
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0, 32'h4); // flag clear
        apb(1'b1, pmc_pkg::OFF_OSC_CTRL, 32'hB0, 32'h0);
        apb(1'b1, pmc_pkg::OFF_CMD, 32'h1, 32'h0);
        repeat (3) @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        chk("restart at zero", 32'h1, restart_zero);
        apb(1'b0, pmc_pkg::OFF_OSC_CTRL, 32'h30, 32'hFFF);
        apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0, 32'h70); // run state
        repeat (3) @(posedge mclk);
        final_report();
    end
endmodule // tb_power_mode_controller
